// ===== core/emcc_pkg.sv
// How it works
// - block bit set refuses every exception except the non-maskable one.
// - leaving any handler other than the NMI one clears the block bit.
// - floor zero has no effect; nonzero floor acts as base priority.
// - with nonzero floor, priority value at or above floor stays pending.
// - only floor bits 7:4 are stored; bits 3:0 read zero, ignore writes.
// - numerically higher priority value means lower exception priority.
// - control register sets thread stack, privilege, reports fp state.
// - control bit 2 reads 1 while a floating-point context is active.
// - exception entry consults fp flag to decide fp state preservation.
// - control bit 1 selects stack: 0 main, 1 process stack pointer.
// - in handler mode the stack-select bit reads zero, ignores writes.
// - every exception return updates the stack-select bit automatically.
// - control bit 0: 0 thread privileged, 1 thread unprivileged.
// - handler mode always runs on the main stack pointer.
// - return rewrites control bits 2:1 from the exception return code; entry only clears the fp flag.
package emcc_pkg;
    // -------------------------------------------------------------------
    // special register selectors
    // -------------------------------------------------------------------
    localparam logic [1:0] EMCC_SEL_BLOCK   = 2'h1;
    localparam logic [1:0] EMCC_SEL_FLOOR   = 2'h2;
    localparam logic [1:0] EMCC_SEL_CONTROL = 2'h3;
    // -------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------
    localparam int EMCC_CTL_PRIV_BIT   = 0;
    localparam int EMCC_CTL_STKSEL_BIT = 1;
    localparam int EMCC_CTL_FPACT_BIT  = 2;
    localparam int EMCC_FLOOR_LSB      = 4;
    localparam int EMCC_FLOOR_W        = 4;
    localparam int EMCC_RET_THREAD_BIT = 3;
    localparam int EMCC_RET_PROC_BIT   = 2;
    localparam int EMCC_RET_NOFP_BIT   = 4;
    localparam logic [3:0] EMCC_FLOOR_RST = 4'h0;
    localparam logic       EMCC_BLOCK_RST = 1'h0;
    localparam logic [2:0] EMCC_CTL_RST   = 3'h0;

    // one special-register move from the pipeline
    typedef struct packed {
        logic        wr;
        logic [1:0]  sel;
        logic [31:0] data;
    } emcc_move_t;

    // exception return event
    typedef struct packed {
        logic        valid;
        logic        from_nmi;
        logic [31:0] code;
    } emcc_ret_t;
endpackage

// ===== core/emcc_gate.sv
`timescale 1ns/1ps
`default_nettype none
module emcc_gate
    import emcc_pkg::*;
#(
    parameter int PW = 4
)(
    input  wire logic          block,      // all-but-nmi block
    input  wire logic [PW-1:0] floor_v,    // priority floor
    input  wire logic [PW-1:0] prio,       // candidate priority
    input  wire logic          is_nmi,     // candidate is nmi
    output logic               allow       // activation permitted
);
    // -------------------------------------------------------------------
    // activation gate
    // -------------------------------------------------------------------
    logic floor_ok;
    // lower value wins; floor zero disables the test
    assign floor_ok = (floor_v == '0)
                   || (prio < floor_v);
    assign allow = is_nmi || (!block && floor_ok);
endmodule
`default_nettype wire

// ===== core/emcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module emcc_top
    import emcc_pkg::*;
(
    input  wire logic        clock,          // core clock
    input  wire logic        rst,            // async reset, high
    input  wire logic        ce,             // clock enable
    input  wire emcc_move_t  move,           // special register move
    input  wire logic        handler_mode,   // core in handler mode
    input  wire logic        exc_entry,      // exception entry pulse
    input  wire emcc_ret_t   exc_ret,        // exception return
    input  wire logic        fp_used,        // fp instruction executed
    input  wire logic        req_valid,      // pending exception offered
    input  wire logic [3:0]  req_prio,       // its priority
    input  wire logic        req_nmi,        // it is the nmi
    output logic [31:0]      rd_data,        // read data for selector
    output logic             activate,       // exception may activate
    output logic             use_proc_stack, // current stack is process
    output logic             thread_unpriv,  // thread unprivileged
    output logic             fp_preserve,    // stack fp state on entry
    output logic             block_out,      // block bit
    output logic [7:0]       floor_out       // floor register
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic       block;
    logic [3:0] floor_v;
    logic [2:0] ctl;
    logic       allow;

    // every check below runs on the core clock and rests during reset
    default clocking core_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // block bit: software write, cleared on non-nmi handler exit
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            block <= EMCC_BLOCK_RST;
        else if (ce)
        begin
            if (exc_ret.valid && !exc_ret.from_nmi)
                block <= 1'b0;
            else if (move.wr && move.sel == EMCC_SEL_BLOCK)
                block <= move.data[0];
        end
    end

    // floor keeps only the upper nibble
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            floor_v <= EMCC_FLOOR_RST;
        else if (ce && move.wr && move.sel == EMCC_SEL_FLOOR)
            floor_v <= move.data[EMCC_FLOOR_LSB +: EMCC_FLOOR_W];
    end

    // control: return code wins over a same-cycle move; an entry only
    // drops the fp flag, so a later return decides the stack again
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ctl <= EMCC_CTL_RST;
        else if (ce)
        begin
            if (exc_ret.valid)
            begin
                ctl[EMCC_CTL_STKSEL_BIT] <= exc_ret.code[EMCC_RET_THREAD_BIT]
                                          & exc_ret.code[EMCC_RET_PROC_BIT];
                ctl[EMCC_CTL_FPACT_BIT]  <= ~exc_ret.code[EMCC_RET_NOFP_BIT];
            end
            else if (exc_entry)
                ctl[EMCC_CTL_FPACT_BIT] <= 1'b0;
            else if (move.wr && move.sel == EMCC_SEL_CONTROL)
            begin
                // privilege is writable in either mode
                ctl[EMCC_CTL_PRIV_BIT]  <= move.data[EMCC_CTL_PRIV_BIT];
                ctl[EMCC_CTL_FPACT_BIT] <= move.data[EMCC_CTL_FPACT_BIT];
                if (!handler_mode)
                    ctl[EMCC_CTL_STKSEL_BIT] <= move.data[EMCC_CTL_STKSEL_BIT];
            end
            else if (fp_used)
                ctl[EMCC_CTL_FPACT_BIT] <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // gate
    // -------------------------------------------------------------------
    emcc_gate #(.PW(4)) u_gate (
        .block   (block),
        .floor_v (floor_v),
        .prio    (req_prio),
        .is_nmi  (req_nmi),
        .allow   (allow)
    );

    // registered outputs; one cycle behind state
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rd_data        <= 32'h0;
            activate       <= 1'b0;
            use_proc_stack <= 1'b0;
            thread_unpriv  <= 1'b0;
            fp_preserve    <= 1'b0;
            block_out      <= 1'b0;
            floor_out      <= 8'h0;
        end
        else if (ce)
        begin
            activate       <= req_valid && allow;
            // handler mode always runs on the main stack
            use_proc_stack <= ctl[EMCC_CTL_STKSEL_BIT] && !handler_mode;
            thread_unpriv  <= ctl[EMCC_CTL_PRIV_BIT];
            fp_preserve    <= ctl[EMCC_CTL_FPACT_BIT];
            block_out      <= block;
            floor_out      <= {floor_v, 4'h0};
            // readback hides the stack select while in handler mode
            case (move.sel)
                EMCC_SEL_BLOCK:   rd_data <= {31'h0, block};
                EMCC_SEL_FLOOR:   rd_data <= {24'h0, floor_v, 4'h0};
                EMCC_SEL_CONTROL: rd_data <= {29'h0,
                                     ctl[EMCC_CTL_FPACT_BIT],
                                     ctl[EMCC_CTL_STKSEL_BIT] & ~handler_mode,
                                     ctl[EMCC_CTL_PRIV_BIT]};
                default:          rd_data <= 32'h0;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    // handler exit other than the nmi one
    sequence ret_non_nmi_s;
        ce && exc_ret.valid && !exc_ret.from_nmi;
    endsequence

    // a candidate offered while the clock is enabled
    sequence offer_s;
        ce && req_valid;
    endsequence

    // a control move that no return or entry outranks
    sequence ctl_move_s;
        ce && move.wr && move.sel == EMCC_SEL_CONTROL
            && !exc_ret.valid && !exc_entry;
    endsequence

    // an fp instruction with nothing of higher rank beside it
    sequence fp_only_s;
        ce && fp_used && !exc_ret.valid && !exc_entry
            && !(move.wr && move.sel == EMCC_SEL_CONTROL);
    endsequence

    block_clear_a: assert property (
        ret_non_nmi_s |=> !block)
        else $error("block bit not cleared on handler exit");

    block_gate_a: assert property (
        offer_s ##0 (block && !req_nmi) |=> !activate)
        else $error("activation while blocked");

    nmi_pass_a: assert property (
        offer_s ##0 req_nmi |=> activate)
        else $error("nmi refused");

    floor_gate_a: assert property (
        offer_s ##0 (floor_v != 4'h0 && req_prio >= floor_v && !req_nmi)
        |=> !activate)
        else $error("activation at or below floor");

    floor_zero_a: assert property (
        offer_s ##0 (!block && floor_v == 4'h0) |=> activate)
        else $error("zero floor blocked activation");

    floor_pass_a: assert property (
        offer_s ##0 (!block && req_prio < floor_v) |=> activate)
        else $error("higher priority refused by floor");

    floor_low_a: assert property (
        1'b1 |-> floor_out[3:0] == 4'h0)
        else $error("floor low bits not zero");

    floor_store_a: assert property (
        (ce && move.wr && move.sel == EMCC_SEL_FLOOR) |=> floor_v
            == $past(move.data[EMCC_FLOOR_LSB +: EMCC_FLOOR_W]))
        else $error("floor upper bits not stored");

    handler_stack_a: assert property (
        (ce && handler_mode) |=> !use_proc_stack)
        else $error("handler on process stack");

    stksel_hold_a: assert property (
        (ce && handler_mode && !exc_ret.valid)
        |=> $stable(ctl[EMCC_CTL_STKSEL_BIT]))
        else $error("stack select changed in handler");

    ret_stksel_a: assert property (
        (ce && exc_ret.valid) |=> ctl[EMCC_CTL_STKSEL_BIT]
            == ($past(exc_ret.code[EMCC_RET_THREAD_BIT])
              & $past(exc_ret.code[EMCC_RET_PROC_BIT])))
        else $error("stack select not set by return");

    priv_write_a: assert property (
        ctl_move_s |=> ctl[EMCC_CTL_PRIV_BIT]
            == $past(move.data[EMCC_CTL_PRIV_BIT]))
        else $error("privilege bit not written");

    fp_set_a: assert property (
        fp_only_s |=> ctl[EMCC_CTL_FPACT_BIT])
        else $error("fp flag not set by fp use");

    entry_fp_a: assert property (
        (ce && exc_entry && !exc_ret.valid) |=> !ctl[EMCC_CTL_FPACT_BIT])
        else $error("fp flag not cleared on entry");

    fp_copy_a: assert property (
        ce |=> fp_preserve == $past(ctl[EMCC_CTL_FPACT_BIT]))
        else $error("fp preserve does not follow fp flag");
endmodule
`default_nettype wire

// ===== verif/exception_mask_and_core_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module exception_mask_and_core_control_tb;
    import emcc_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    emcc_move_t  move = '0;
    logic        handler_mode = 1'b0;
    logic        exc_entry = 1'b0;
    emcc_ret_t   exc_ret = '0;
    logic        fp_used = 1'b0;
    logic        req_valid = 1'b0;
    logic [3:0]  req_prio = 4'h0;
    logic        req_nmi = 1'b0;
    logic [31:0] rd_data;
    logic        activate, use_proc_stack, thread_unpriv;
    logic        fp_preserve, block_out;
    logic [7:0]  floor_out;
    integer      fail_count = 0;
    integer      compares = 0;
    integer      seed = 32'h920cb21b;
    logic [3:0]  fl;
    logic        bk;
    logic [31:0] ex, act_w;
    // ---------------------------------------------------------------
    // clock and device
    // ---------------------------------------------------------------
    // 250 mhz core clock
    always #2 clock = ~clock;
    emcc_top dut_u (.clock(clock), .rst(rst), .ce(ce), .move(move),
        .handler_mode(handler_mode), .exc_entry(exc_entry),
        .exc_ret(exc_ret), .fp_used(fp_used), .req_valid(req_valid),
        .req_prio(req_prio), .req_nmi(req_nmi), .rd_data(rd_data),
        .activate(activate), .use_proc_stack(use_proc_stack),
        .thread_unpriv(thread_unpriv), .fp_preserve(fp_preserve),
        .block_out(block_out), .floor_out(floor_out));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // inputs move 1 ns after the edge, outputs settled by then
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    // one-cycle move, then one edge for the registered copies
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        move = '{1'b1, s, d};
        step(1);
        move.wr = 1'b0;
        step(1);
    endtask
    task automatic ret(input logic nmi, input logic [31:0] c);
        exc_ret = '{1'b1, nmi, c};
        step(1);
        exc_ret.valid = 1'b0;
        step(1);
    endtask
    // nmi always passes; floor zero never blocks; lower value wins
    function automatic logic exp_act(input logic b, input logic [3:0] f,
                                     input logic [3:0] p, input logic n);
        return n | (!b && (f == 4'h0 || p < f));
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #40000;
        fail_count++;
        summarize();
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            move.sel = s[1:0];
            step(1);
            chk("reset rd", rd_data, 32'h0);
        end
        chk("reset outs", {19'h0, activate, use_proc_stack, thread_unpriv,
            fp_preserve, block_out, floor_out}, 32'h0);
        $display("reset values done");
        wr(EMCC_SEL_FLOOR, 32'h55);
        chk("floor_out", {24'h0, floor_out}, 32'h50);
        chk("floor rd", rd_data, 32'h50);
        ce = 1'b0;
        wr(EMCC_SEL_FLOOR, 32'hf0);
        chk("frozen floor", {24'h0, floor_out}, 32'h50);
        ce = 1'b1;
        $display("floor storage done");
        for (int i = 0; i < 40; i++)
        begin
            fl = (i < 2) ? 4'h0 : (i == 2) ? 4'h4 : 4'($random(seed));
            bk = (i < 4) ? 1'b0 : (i == 4) ? 1'b1 : 1'($random(seed));
            wr(EMCC_SEL_FLOOR, {24'h0, fl, 4'h0});
            wr(EMCC_SEL_BLOCK, {31'h0, bk});
            req_valid = (i < 6) ? 1'b1 : 1'($random(seed));
            req_prio = (i == 2 || i == 3) ? fl : 4'($random(seed));
            req_nmi = (i == 4) || ((i > 5) && (($random(seed) & 3) == 0));
            step(1);
            ex = {31'h0, req_valid & exp_act(bk, fl, req_prio, req_nmi)};
            act_w = {31'h0, activate};
            chk("act", act_w, ex);
            req_valid = 1'b0;
        end
        $display("activation gate done");
        wr(EMCC_SEL_BLOCK, 32'h1);
        ret(1'b1, 32'h0);
        chk("block after nmi", {31'h0, block_out}, 32'h1);
        ret(1'b0, 32'h0);
        chk("block after ret", {31'h0, block_out}, 32'h0);
        $display("block clear done");
        exc_entry = 1'b1;
        step(1);
        exc_entry = 1'b0;
        wr(EMCC_SEL_CONTROL, 32'h3);
        chk("ctl rd", rd_data, 32'h3);
        chk("use_proc_stack", {31'h0, use_proc_stack}, 32'h1);
        chk("unpriv", {31'h0, thread_unpriv}, 32'h1);
        handler_mode = 1'b1;
        wr(EMCC_SEL_CONTROL, 32'h0);
        chk("handler rd", rd_data, 32'h0);
        chk("handler stack", {31'h0, use_proc_stack}, 32'h0);
        handler_mode = 1'b0;
        step(1);
        chk("stksel kept", rd_data, 32'h2);
        chk("priv written", {31'h0, thread_unpriv}, 32'h0);
        ret(1'b0, 32'h08);
        chk("ret fp", rd_data, 32'h4);
        chk("preserve", {31'h0, fp_preserve}, 32'h1);
        ret(1'b0, 32'h1c);
        chk("ret proc", rd_data, 32'h2);
        chk("no preserve", {31'h0, fp_preserve}, 32'h0);
        chk("ret stack", {31'h0, use_proc_stack}, 32'h1);
        fp_used = 1'b1;
        step(1);
        fp_used = 1'b0;
        step(1);
        chk("fp used", rd_data & 32'h4, 32'h4);
        exc_entry = 1'b1;
        step(1);
        exc_entry = 1'b0;
        step(1);
        chk("entry fp", {31'h0, fp_preserve}, 32'h0);
        $display("control register done");
        summarize();
    end
endmodule
`default_nettype wire
